//--- design/storage_key_ref_change_recorder.sv
// storage keys with reference and change recording, address routing,
// implicit address stores and load-real-address results
// assumes one access and one key operation at most per cycle, translator outside
// Function
// R1: seven-bit key kept per 2K real block
// R2: any fetch sets that block's reference bit
// R3: any store sets change and reference bits
// R4: recording active regardless of mode or translation
// R5: console store/display recorded like other accesses
// R6: reset-reference clears reference bit only
// R7: cpu buffer-hit fetch does not set reference
// R8: prefetch may set reference; that is allowed
// R9: software clears change bit via key set
// R10: software clears both blocks of 4K frame
// R11: translate program addresses, event bounds included
// R12: key operands, non-storage values, io lists untranslated
// R13: table origins and frame address used real
// R14: implicit psw, restart, timer addresses are real
// R15: translation exception stores virtual address at 144
// R16: event interruption stores virtual address at 152
// R17: failing storage address at 248 is real
// R18: real-address load returns real or entry address
// R19: recording visible by access completion, never lost
`timescale 1ns/1ps
module storage_key_ref_change_recorder #(
  parameter int REAL_AW = skey_pkg::REAL_AW,
  parameter int BLOCK_SHIFT = skey_pkg::BLOCK_SHIFT
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // storage access from cpu, channels and console
  input wire skey_pkg::access_req_t access,
  output logic access_done,
  // key instructions
  input wire skey_pkg::key_op_t key_op,
  output logic key_op_done,
  output logic [skey_pkg::KEY_W-1:0] key_rdata,
  // program address routing
  input wire logic translation_on,
  input wire skey_pkg::addr_req_t addr_req,
  output logic xlate_valid,
  output logic real_valid,
  output logic [REAL_AW-1:0] route_addr,
  // interruption events
  input wire logic xlate_exc,
  input wire logic [REAL_AW-1:0] xlate_exc_vaddr,
  input wire logic event_intr,
  input wire logic [REAL_AW-1:0] event_vaddr,
  input wire logic storage_fail,
  input wire logic [REAL_AW-1:0] storage_fail_raddr,
  output skey_pkg::implicit_store_t implicit_store,
  // load real address results from the translator
  input wire logic lra_resp,
  input wire logic lra_ok,
  input wire logic [REAL_AW-1:0] lra_real_addr,
  input wire logic [REAL_AW-1:0] lra_entry_addr,
  output logic lra_valid,
  output logic lra_fault,
  output logic [REAL_AW-1:0] lra_addr
);

  localparam int NBLK = 1 << (REAL_AW - BLOCK_SHIFT);
  localparam int BW = REAL_AW - BLOCK_SHIFT;

  function automatic logic [BW-1:0] block_of(input logic [REAL_AW-1:0] a);
    block_of = a[REAL_AW-1:BLOCK_SHIFT];
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // key store

  // protect and fetch-protect bits live in a plain array, no reset needed
  // limitation: a block reads unknown protect bits until its first key set
  // one access and one key op per cycle; more requesters need an arbiter ahead
  logic [skey_pkg::PROT_W:0] prot_mem [NBLK];
  // reference and change bits are flops so hardware can set them each cycle
  logic [NBLK-1:0] ref_bits; // [R1]
  logic [NBLK-1:0] chg_bits; // [R1]

  wire [BW-1:0] acc_blk;
  wire [BW-1:0] op_blk;
  wire acc_counts;
  wire acc_store;
  wire acc_ref;
  wire acc_chg;
  wire op_set;
  wire op_insert;
  wire op_reset_ref;
  wire same_blk;
  wire [skey_pkg::PROT_W:0] set_prot;
  wire set_ref;
  wire set_chg;
  wire next_ref_op;
  wire next_chg_op;

  assign acc_blk = block_of(access.addr);
  assign op_blk = block_of(key_op.addr);

  // only a cpu fetch served from the buffer skips main storage [R7]
  // console and channel accesses count like cpu ones [R5] [R2]
  // no mode input gates recording [R4]
  assign acc_counts = access.valid &&
                      !((access.src == skey_pkg::SRC_CPU) &&
                        (access.kind == skey_pkg::ACC_FETCH) && access.buffer_hit);
  assign acc_store = access.kind == skey_pkg::ACC_STORE;
  assign acc_ref = acc_counts; // [R2] [R3]
  assign acc_chg = acc_counts && acc_store; // [R3]
  // prefetches arrive as ordinary fetches and may mark unused frames [R8]

  assign op_set = key_op.valid && (key_op.op == skey_pkg::KOP_SET);
  assign op_insert = key_op.valid && (key_op.op == skey_pkg::KOP_INSERT);
  assign op_reset_ref = key_op.valid && (key_op.op == skey_pkg::KOP_RESET_REF);
  assign same_blk = acc_blk == op_blk;

  assign set_prot = key_op.key[skey_pkg::KEY_W-1:skey_pkg::KEY_FETCH_PROT_BIT];
  assign set_ref = key_op.key[skey_pkg::KEY_REF_BIT];
  // key set is the only path that clears the change bit [R9]
  assign set_chg = key_op.key[skey_pkg::KEY_CHG_BIT];

  // a simultaneous access to the same block wins over any clear [R19]
  assign next_ref_op = (op_reset_ref ? 1'b0 : set_ref) || (same_blk && acc_ref);
  assign next_chg_op = set_chg || (same_blk && acc_chg);

  always_ff @(posedge clk) begin
    if (op_set) begin
      prot_mem[op_blk] <= set_prot; // [R1]
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ref_bits <= '0;
      chg_bits <= '0;
    end else begin
      if (acc_ref) begin
        ref_bits[acc_blk] <= 1'b1; // [R2] [R3]
      end
      if (acc_chg) begin
        chg_bits[acc_blk] <= 1'b1; // [R3]
      end
      // reset-reference leaves protect, fetch-protect and change alone [R6]
      if (op_set || op_reset_ref) begin
        ref_bits[op_blk] <= next_ref_op; // [R6]
      end
      if (op_set) begin
        chg_bits[op_blk] <= next_chg_op; // [R9]
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // key read and completion

  wire [skey_pkg::KEY_W-1:0] read_key;
  // bypass so a key read sees an access that lands in the same cycle [R19]
  assign read_key = {prot_mem[op_blk],
                     ref_bits[op_blk] || (same_blk && acc_ref),
                     chg_bits[op_blk] || (same_blk && acc_chg)};

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      access_done <= 1'b0;
      key_op_done <= 1'b0;
      key_rdata <= skey_pkg::KEY_RESET;
    end else begin
      // done rises on the edge that already holds the recorded bits [R19]
      access_done <= access.valid;
      key_op_done <= key_op.valid;
      if (op_insert) begin
        key_rdata <= read_key;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // address routing

  skey_pkg::addr_class_t verdict;

  addr_classifier u_class (
    .req(addr_req),
    .translation_on(translation_on),
    .verdict(verdict)
  );

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      xlate_valid <= 1'b0;
      real_valid <= 1'b0;
      route_addr <= '0;
    end else begin
      xlate_valid <= addr_req.valid && verdict.to_storage && verdict.translate; // [R11]
      real_valid <= addr_req.valid && verdict.to_storage && !verdict.translate; // [R13] [R14]
      if (addr_req.valid) begin
        route_addr <= verdict.addr;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // implicit interruption address stores

  // events may coincide; each kind holds its latest event until it is sent out
  logic pend_exc;
  logic pend_evt;
  logic pend_fail;
  logic [REAL_AW-1:0] exc_addr;
  logic [REAL_AW-1:0] evt_addr;
  logic [REAL_AW-1:0] fail_addr;

  wire any_exc;
  wire any_evt;
  wire any_fail;
  wire send_exc;
  wire send_evt;
  wire send_fail;
  wire keep_exc;
  wire keep_evt;
  wire keep_fail;

  assign any_exc = pend_exc || xlate_exc;
  assign any_evt = pend_evt || event_intr;
  assign any_fail = pend_fail || storage_fail;
  // fixed priority, one store per cycle
  assign send_exc = any_exc;
  assign send_evt = any_evt && !any_exc;
  assign send_fail = any_fail && !any_exc && !any_evt;
  // a fresh event goes out at once or waits; one that lands while an older
  // one of its kind leaves stays pending, so none is sent twice; one landing while an older one waits replaces it
  // the exception outranks all, so it never has to wait
  assign keep_exc = xlate_exc && (pend_exc || !send_exc);
  assign keep_evt = event_intr && (pend_evt || !send_evt);
  assign keep_fail = storage_fail && (pend_fail || !send_fail);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pend_exc <= 1'b0;
      pend_evt <= 1'b0;
      pend_fail <= 1'b0;
      exc_addr <= '0;
      evt_addr <= '0;
      fail_addr <= '0;
    end else begin
      // a new event beats the clear of the one being sent
      pend_exc <= keep_exc || (pend_exc && !send_exc);
      pend_evt <= keep_evt || (pend_evt && !send_evt);
      pend_fail <= keep_fail || (pend_fail && !send_fail);
      if (xlate_exc) begin
        exc_addr <= xlate_exc_vaddr; // [R15]
      end
      if (event_intr) begin
        evt_addr <= event_vaddr; // [R16]
      end
      if (storage_fail) begin
        fail_addr <= storage_fail_raddr; // [R17]
      end
    end
  end

  wire [REAL_AW-1:0] exc_src;
  wire [REAL_AW-1:0] evt_src;
  wire [REAL_AW-1:0] fail_src;
  assign exc_src = pend_exc ? exc_addr : xlate_exc_vaddr;
  assign evt_src = pend_evt ? evt_addr : event_vaddr;
  assign fail_src = pend_fail ? fail_addr : storage_fail_raddr;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      implicit_store <= '0;
    end else begin
      implicit_store.valid <= send_exc || send_evt || send_fail;
      if (send_exc) begin
        implicit_store.loc <= skey_pkg::LOC_XLATE_EXC; // [R15]
        implicit_store.addr <= exc_src; // [R15]
      end else if (send_evt) begin
        implicit_store.loc <= skey_pkg::LOC_EVENT_ADDR; // [R16]
        implicit_store.addr <= evt_src; // [R16]
      end else if (send_fail) begin
        implicit_store.loc <= skey_pkg::LOC_FAIL_ADDR; // [R17]
        implicit_store.addr <= fail_src; // [R17]
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // load real address result

  // on failure the entry address is handed back instead of a frame address
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      lra_valid <= 1'b0;
      lra_fault <= 1'b0;
      lra_addr <= '0;
    end else begin
      lra_valid <= lra_resp;
      if (lra_resp) begin
        lra_fault <= !lra_ok;
        lra_addr <= lra_ok ? lra_real_addr : lra_entry_addr; // [R18]
      end
    end
  end

endmodule

//--- design/skey_pkg.sv
// shared types and constants for the storage key recorder
// assumes a 24-bit real address space split into 2K blocks
package skey_pkg;

  // address space and key layout
  localparam int REAL_AW = 24;
  localparam int BLOCK_SHIFT = 11;
  localparam int KEY_W = 7;
  localparam int PROT_W = 4;
  localparam int KEY_PROT_LSB = 3;
  localparam int KEY_FETCH_PROT_BIT = 2;
  localparam int KEY_REF_BIT = 1;
  localparam int KEY_CHG_BIT = 0;
  localparam logic [KEY_W-1:0] KEY_RESET = 7'h00;

  // implicit low-storage locations
  localparam logic [REAL_AW-1:0] LOC_TIMER = 24'h000050;
  localparam logic [REAL_AW-1:0] LOC_XLATE_EXC = 24'h000090;
  localparam logic [REAL_AW-1:0] LOC_EVENT_ADDR = 24'h000098;
  localparam logic [REAL_AW-1:0] LOC_FAIL_ADDR = 24'h0000F8;

  // control register numbers behind certain purposes
  localparam logic [3:0] CR_SEG_ORIGIN = 4'h1;
  localparam logic [3:0] CR_EVENT_START = 4'hA;
  localparam logic [3:0] CR_EVENT_END = 4'hB;

  typedef enum logic [1:0] {
    SRC_CPU,
    SRC_CHANNEL,
    SRC_CONSOLE
  } access_src_t;

  typedef enum logic {
    ACC_FETCH,
    ACC_STORE
  } access_kind_t;

  typedef enum logic [1:0] {
    KOP_SET,
    KOP_INSERT,
    KOP_RESET_REF
  } key_op_kind_t;

  // why the program presents an address
  typedef enum logic [3:0] {
    PUR_INSTR,
    PUR_BRANCH,
    PUR_OPERAND,
    PUR_LRA_OPERAND,
    PUR_EVENT_BOUND,
    PUR_KEY_OPERAND,
    PUR_NO_STORAGE,
    PUR_IO_LIST,
    PUR_SEG_ORIGIN,
    PUR_PAGE_ORIGIN,
    PUR_FRAME_ADDR,
    PUR_INTR_PSW,
    PUR_RESTART,
    PUR_TIMER
  } addr_purpose_t;

  typedef struct packed {
    logic valid;
    access_src_t src;
    access_kind_t kind;
    logic buffer_hit;
    logic [REAL_AW-1:0] addr;
  } access_req_t;

  typedef struct packed {
    logic valid;
    key_op_kind_t op;
    logic [REAL_AW-1:0] addr;
    logic [KEY_W-1:0] key;
  } key_op_t;

  typedef struct packed {
    logic valid;
    addr_purpose_t purpose;
    logic [3:0] cr_num;
    logic [REAL_AW-1:0] addr;
  } addr_req_t;

  typedef struct packed {
    logic translate;
    logic to_storage;
    logic [REAL_AW-1:0] addr;
  } addr_class_t;

  typedef struct packed {
    logic valid;
    logic [REAL_AW-1:0] loc;
    logic [REAL_AW-1:0] addr;
  } implicit_store_t;

endpackage

//--- design/addr_classifier.sv
// decides whether a program address goes through translation
// assumes purpose and control register number come from the decoder
`timescale 1ns/1ps
module addr_classifier (
  // request
  input wire skey_pkg::addr_req_t req,
  input wire logic translation_on,
  // verdict
  output skey_pkg::addr_class_t verdict
);

  wire is_virtual_kind;
  wire is_no_storage;
  wire is_timer;
  wire event_cr_ok;

  // event bounds only count when they come from the two bound registers
  assign event_cr_ok = (req.cr_num == skey_pkg::CR_EVENT_START) ||
                       (req.cr_num == skey_pkg::CR_EVENT_END);

  assign is_virtual_kind = (req.purpose == skey_pkg::PUR_INSTR) ||
                           (req.purpose == skey_pkg::PUR_BRANCH) ||
                           (req.purpose == skey_pkg::PUR_OPERAND) ||
                           (req.purpose == skey_pkg::PUR_LRA_OPERAND) ||
                           ((req.purpose == skey_pkg::PUR_EVENT_BOUND) && event_cr_ok); // [R11]

  // shift amounts never touch storage [R12]
  assign is_no_storage = (req.purpose == skey_pkg::PUR_NO_STORAGE);
  assign is_timer = (req.purpose == skey_pkg::PUR_TIMER);

  // key operands, io lists, table origins and implicit ones stay real [R12] [R13] [R14]
  assign verdict.translate = translation_on && is_virtual_kind && !is_no_storage; // [R11]
  assign verdict.to_storage = !is_no_storage;
  // timer update always goes to its fixed real location [R14]
  assign verdict.addr = is_timer ? skey_pkg::LOC_TIMER : req.addr;

endmodule

//--- verif/access_issuer.sv
// far-side model: cpu, channels and console issuing storage accesses
// assumes the bench hands it one request word per cycle
`timescale 1ns/1ps
module access_issuer (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // request from the bench
  input wire skey_pkg::access_req_t cmd,
  // to the recorder
  output skey_pkg::access_req_t access
);
  // idle lines toggle so a stale address is never read as a request
  // prefetch goes out as an ordinary fetch
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      access <= '0;
    end else begin
      access <= cmd.valid ? cmd : skey_pkg::access_req_t'{1'b0, access.src, access.kind,
        ~access.buffer_hit, ~access.addr};
    end
  end
endmodule

//--- verif/skey_asserts.sv
// port checker for the storage key recorder
// assumes skey_pkg compiled first; bound onto the recorder
`timescale 1ns/1ps
module skey_asserts #(
  parameter int REAL_AW = 24,
  parameter int BLOCK_SHIFT = 11
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // accesses and key ops
  input wire skey_pkg::access_req_t access,
  input wire logic access_done,
  input wire skey_pkg::key_op_t key_op,
  input wire logic key_op_done,
  // routing
  input wire logic translation_on,
  input wire skey_pkg::addr_req_t addr_req,
  input wire logic xlate_valid,
  input wire logic real_valid,
  input wire logic [REAL_AW-1:0] route_addr,
  // implicit stores
  input wire logic xlate_exc,
  input wire logic [REAL_AW-1:0] xlate_exc_vaddr,
  input wire logic event_intr,
  input wire logic [REAL_AW-1:0] event_vaddr,
  input wire logic storage_fail,
  input wire logic [REAL_AW-1:0] storage_fail_raddr,
  input wire skey_pkg::implicit_store_t implicit_store,
  // load real address
  input wire logic lra_resp,
  input wire logic lra_ok,
  input wire logic lra_valid,
  input wire logic lra_fault,
  input wire logic [REAL_AW-1:0] lra_real_addr,
  input wire logic [REAL_AW-1:0] lra_entry_addr,
  input wire logic [REAL_AW-1:0] lra_addr
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  ////////////////////////////////////////////////
  sequence trio_s;
    xlate_exc && event_intr && storage_fail;
  endsequence
  // quiet long enough that nothing of higher rank is pending
  sequence calm_s;
    (!xlate_exc && !event_intr)[*3];
  endsequence
  ////////////////////////////////////////////////
  acc_done_a: assert property (access.valid |=> access_done)
    else $error("access not completed");
  kop_done_a: assert property (key_op.valid |=> key_op_done)
    else $error("key op not completed");
  virt_route_a: assert property (addr_req.valid && translation_on && addr_req.purpose inside {
    skey_pkg::PUR_INSTR, skey_pkg::PUR_OPERAND} |=> xlate_valid && !real_valid
    && route_addr == $past(addr_req.addr)) else $error("program address not translated");
  keep_real_a: assert property (addr_req.valid && addr_req.purpose inside {
    skey_pkg::PUR_KEY_OPERAND, skey_pkg::PUR_IO_LIST} |=> real_valid && !xlate_valid)
    else $error("untranslated address sent to translator");
  no_store_a: assert property (addr_req.valid && addr_req.purpose == skey_pkg::PUR_NO_STORAGE
    |=> !xlate_valid && !real_valid) else $error("non-storage value routed");
  table_real_a: assert property (addr_req.valid && addr_req.purpose inside {
    skey_pkg::PUR_SEG_ORIGIN, skey_pkg::PUR_FRAME_ADDR} |=> real_valid && !xlate_valid)
    else $error("table origin translated");
  timer_real_a: assert property (addr_req.valid && addr_req.purpose == skey_pkg::PUR_TIMER
    |=> real_valid && route_addr == skey_pkg::LOC_TIMER) else $error("timer address wrong");
  xexc_store_a: assert property (xlate_exc |=> implicit_store.valid &&
    implicit_store.loc == skey_pkg::LOC_XLATE_EXC && implicit_store.addr == $past(xlate_exc_vaddr))
    else $error("exception address store wrong");
  event_store_a: assert property (trio_s ##1 (!xlate_exc && !event_intr) |=>
    implicit_store.valid && implicit_store.loc == skey_pkg::LOC_EVENT_ADDR &&
    implicit_store.addr == $past(event_vaddr, 2)) else $error("event address store wrong");
  fail_store_a: assert property (calm_s ##0 storage_fail |=> implicit_store.valid &&
    implicit_store.loc == skey_pkg::LOC_FAIL_ADDR && implicit_store.addr == $past(storage_fail_raddr))
    else $error("failing address store wrong");
  lra_result_a: assert property (lra_resp |=> lra_valid && lra_fault == !$past(lra_ok) &&
    lra_addr == ($past(lra_ok) ? $past(lra_real_addr) : $past(lra_entry_addr)))
    else $error("load real address result wrong");
endmodule
bind storage_key_ref_change_recorder skey_asserts #(.REAL_AW(REAL_AW),
  .BLOCK_SHIFT(BLOCK_SHIFT)) u_chk (.*);

//--- verif/storage_key_ref_change_recorder_tb.sv
// self-checking bench for the storage key recorder
// assumes skey_pkg, the recorder, its checker and access_issuer compiled first
`timescale 1ns/1ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin err_total++; \
  $display("MISMATCH t=%0t got %h exp %h", $time, (a), (e)); end end
module storage_key_ref_change_recorder_tb;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic translation_on = 1'b0;
  logic xlate_exc = 1'b0, event_intr = 1'b0, storage_fail = 1'b0;
  logic lra_resp = 1'b0, lra_ok = 1'b0;
  logic [23:0] xlate_exc_vaddr = 24'hABC123, event_vaddr = 24'h456DEF;
  logic [23:0] storage_fail_raddr = 24'h0FEDCB;
  logic [23:0] lra_real_addr = 24'h123000, lra_entry_addr = 24'h00F008;
  skey_pkg::access_req_t cmd = '0;
  skey_pkg::access_req_t access;
  skey_pkg::key_op_t key_op = '0;
  skey_pkg::addr_req_t addr_req = '0;
  skey_pkg::implicit_store_t implicit_store;
  logic access_done, key_op_done, xlate_valid, real_valid, lra_valid, lra_fault;
  logic [6:0] key_rdata;
  logic [23:0] route_addr, lra_addr;
  int err_total = 0, tests_run = 0, cycles = 0;
  // row nibbles: purpose, control register, {translation on, xlate, real, 0}
  localparam logic [11:0] ROWS [17] = '{12'h00C, 12'h10C, 12'h20C, 12'h30C, 12'h4AC,
    12'h4BC, 12'h43A, 12'h202, 12'h50A, 12'h608, 12'h70A, 12'h81A, 12'h90A, 12'hA0A,
    12'hB0A, 12'hC0A, 12'hD0A};
  localparam skey_pkg::implicit_store_t ST_EXP [3] = '{
    '{1'b1, skey_pkg::LOC_XLATE_EXC, 24'hABC123},
    '{1'b1, skey_pkg::LOC_EVENT_ADDR, 24'h456DEF},
    '{1'b1, skey_pkg::LOC_FAIL_ADDR, 24'h0FEDCB}};
  always #2.5 clk = ~clk;
  access_issuer partner (.*);
  storage_key_ref_change_recorder #(.REAL_AW(24), .BLOCK_SHIFT(11)) dut (.*);
  ////////////////////////////////////////////////
  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic note(string s);
    $display("test %0s done", s);
  endtask
  task automatic kop(skey_pkg::key_op_kind_t op, logic [23:0] a, logic [6:0] k);
    @(posedge clk);
    key_op <= '{1'b1, op, a, k};
    @(posedge clk);
    key_op <= '0;
    #1;
    `CHK(key_op_done, 1'b1)
  endtask
  task automatic look(logic [23:0] a, logic [6:0] e);
    kop(skey_pkg::KOP_INSERT, a, 7'h00);
    `CHK(key_rdata, e)
  endtask
  task automatic acc(skey_pkg::access_src_t s, skey_pkg::access_kind_t k, logic h,
    logic [23:0] a);
    @(posedge clk);
    cmd <= '{1'b1, s, k, h, a};
    @(posedge clk);
    cmd <= '0;
    @(posedge clk);
    #1;
    `CHK(access_done, 1'b1)
  endtask
  ////////////////////////////////////////////////
  // hang guard, run needs about 110 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      err_total++;
      summarize();
    end
  end
  initial begin
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    #1;
    `CHK({access_done, key_op_done, implicit_store.valid, lra_valid}, 4'h0)
    note("reset");
    kop(skey_pkg::KOP_SET, 24'h000800, 7'h7C);
    look(24'h000800, 7'h7C);
    acc(skey_pkg::SRC_CPU, skey_pkg::ACC_FETCH, 1'b1, 24'h000800);
    look(24'h000800, 7'h7C);
    acc(skey_pkg::SRC_CPU, skey_pkg::ACC_FETCH, 1'b0, 24'h000FFF);
    look(24'h000800, 7'h7E);
    acc(skey_pkg::SRC_CHANNEL, skey_pkg::ACC_STORE, 1'b0, 24'h000A00);
    look(24'h000800, 7'h7F);
    kop(skey_pkg::KOP_RESET_REF, 24'h000800, 7'h00);
    look(24'h000800, 7'h7D);
    note("key bits");
    // blocks at 800 and 1000 cleared on page-in, one half from each of two adjacent 4K frames
    kop(skey_pkg::KOP_SET, 24'h000800, 7'h00);
    kop(skey_pkg::KOP_SET, 24'h001000, 7'h00);
    acc(skey_pkg::SRC_CHANNEL, skey_pkg::ACC_FETCH, 1'b1, 24'h000800);
    look(24'h000800, 7'h02);
    acc(skey_pkg::SRC_CONSOLE, skey_pkg::ACC_STORE, 1'b0, 24'h0017FF);
    look(24'h001000, 7'h03);
    kop(skey_pkg::KOP_SET, 24'h001000, 7'h00);
    acc(skey_pkg::SRC_CONSOLE, skey_pkg::ACC_FETCH, 1'b0, 24'h001000);
    look(24'h001000, 7'h02);
    note("sources");
    for (int i = 0; i < 17; i++) begin
      @(posedge clk);
      translation_on <= ROWS[i][3];
      addr_req <= '{1'b1, skey_pkg::addr_purpose_t'(ROWS[i][11:8]), ROWS[i][7:4],
        24'h012340 + 24'(i)};
      @(posedge clk);
      addr_req <= '0;
      #1;
      `CHK({xlate_valid, real_valid}, ROWS[i][2:1])
      if (ROWS[i][2:1] != 2'b00) `CHK(route_addr, ROWS[i][11:8] == 4'hD ?
        skey_pkg::LOC_TIMER : 24'h012340 + 24'(i))
    end
    note("routing");
    // the last row left translation on; recording must not care
    kop(skey_pkg::KOP_RESET_REF, 24'h000800, 7'h00);
    acc(skey_pkg::SRC_CPU, skey_pkg::ACC_STORE, 1'b0, 24'h000C00);
    look(24'h000800, 7'h03);
    note("recording under translation");
    @(posedge clk);
    xlate_exc <= 1'b1;
    event_intr <= 1'b1;
    storage_fail <= 1'b1;
    @(posedge clk);
    {xlate_exc, event_intr, storage_fail} <= 3'h0;
    for (int i = 0; i < 3; i++) begin
      #1;
      `CHK(implicit_store, ST_EXP[i])
      @(posedge clk);
    end
    repeat (3) @(posedge clk);
    storage_fail <= 1'b1;
    @(posedge clk);
    storage_fail <= 1'b0;
    #1;
    `CHK(implicit_store, ST_EXP[2])
    note("implicit stores");
    for (int i = 0; i < 2; i++) begin
      @(posedge clk);
      lra_resp <= 1'b1;
      lra_ok <= i[0];
      @(posedge clk);
      lra_resp <= 1'b0;
      #1;
      `CHK({lra_valid, lra_fault, lra_addr}, {1'b1, !i[0], i[0] ? 24'h123000 : 24'h00F008})
    end
    note("load real address");
    @(posedge clk);
    rstn <= 1'b0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    #1;
    `CHK({access_done, key_op_done, implicit_store.valid, lra_valid, key_rdata}, 11'h000)
    look(24'h000800, 7'h00);
    note("second reset");
    summarize();
  end
endmodule
